// ==== hdl/gtc_pkg.sv ====
// Constants for the gated 16-bit timer/counter
package gtc_pkg;
	// ==========================================
	// Register byte addresses (Wishbone, one word each)
	localparam logic [3:0] ADDR_COUNT_LOW = 4'h0;
	localparam logic [3:0] ADDR_COUNT_HIGH = 4'h4;
	localparam logic [3:0] ADDR_COUNTER_CONTROL = 4'h8;
	localparam logic [3:0] ADDR_GATE_CONTROL = 4'hC;
	// ==========================================
	// Counter control fields
	localparam int CC_ON_BIT = 0;
	localparam int CC_SYNC_DIS_BIT = 2;
	localparam int CC_SECONDARY_OSCILLATOR_EN_BIT = 3;
	localparam int CC_PRESC_LSB = 4;
	localparam int CC_CS_LSB = 6;
	localparam logic [7:0] CC_WRITE_MASK = 8'hFD;
	// Gate control fields
	localparam int GC_GSS_LSB = 0;
	localparam int GC_GVAL_BIT = 2;
	localparam int GC_TOGGLE_BIT = 5;
	localparam int GC_POL_BIT = 6;
	localparam int GC_EN_BIT = 7;
	localparam int GC_OVF_FLAG_BIT = 3;
	localparam logic [7:0] GC_WRITE_MASK = 8'hE3;
	// ==========================================
	// Clock and gate source codes, last instruction divider step and count maximum
	localparam logic [1:0] CS_INSTR = 2'h0;
	localparam logic [1:0] CS_SYSCLK = 2'h1;
	localparam logic [1:0] CS_EXTERNAL = 2'h2;
	localparam logic [1:0] CS_LFOSC = 2'h3;
	localparam logic [1:0] GS_PIN = 2'h0;
	localparam logic [1:0] GS_TIMER_OVF = 2'h1;
	localparam logic [1:0] GS_CMP1 = 2'h2;
	localparam logic [1:0] GS_CMP2 = 2'h3;
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage : gtc_pkg

// ==== hdl/gtc_timer.sv ====
// Gated 16-bit timer/counter with classic Wishbone register slave
`timescale 1ns/1ps

// Functional notes
// - 16-bit up counter read/written as two bytes; writes load counter directly.
// - Off when on bit clear; free run without gate enable; gated otherwise.
// - Source field: 11 low-freq osc, 10 external, 01 system, 00 instruction clock.
// - Internal sources count prescaled clocks; system clock gives four per instruction.
// - External source counts rising edges, synchronized or asynchronous.
// - Counter mode needs a falling edge before first counted rising edge.
// - Prescale 1,2,4,8; prescale counter hidden, cleared on any count write.
// - Oscillator enable bit starts the crystal oscillator; it keeps running in sleep.
// - Sync-disable counts external input unsynchronized; runs in sleep, overflow wakes.
// - Sync/async switching may lose or add one increment.
// - Byte reads while counting asynchronously return valid values.
// - Gated mode counts only while gate active, otherwise holds.
// - Polarity 0 counts gate low, 1 counts gate high, all sources.
// - Gate source: 00 pin, 01 timer overflow, 10 comparator 1, 11 comparator 2.
// - Other timer wrap makes a rising pulse into the gate logic.
// - Comparator gate source selectable synchronized or asynchronous.
// - Toggle mode routes gate through flip-flop toggling on each incrementing edge.
// - Toggle flip-flop cleared and held clear while toggle mode off.
// - Wrap from FFFFh to 0000h sets overflow flag; software clears it.
// - Clearing on bit stops counting and clears gate flip-flop.
// - Internal sources ignore the sync control bit.
// - External source: oscillator enable clear picks pin, set picks secondary oscillator.
module gtc_timer (
	input wire logic i_mclk, // System clock, 200 MHz
	input wire logic i_rst, // Async reset, active high
	input wire logic i_wb_cyc, // Wishbone cycle
	input wire logic i_wb_stb, // Wishbone strobe
	input wire logic i_wb_we, // Wishbone write enable
	input wire logic [3:0] i_wb_adr, // Wishbone byte address
	input wire logic [3:0] i_wb_sel, // Wishbone byte selects
	input wire logic [31:0] i_wb_dat, // Wishbone write data
	output logic [31:0] o_wb_dat, // Wishbone read data
	output logic o_wb_ack, // Wishbone acknowledge
	input wire logic i_ext_clock_input, // External count clock pin
	input wire logic i_secondary_oscillator, // Secondary oscillator clock
	input wire logic i_low_freq_internal_osc, // Low-frequency internal osc clock
	input wire logic i_gate_input_pin, // Gate pin
	input wire logic i_other_8bit_timer_wrap, // Other timer wrap pulse
	input wire logic i_cmp1_out, // Comparator 1 output
	input wire logic i_cmp2_out, // Comparator 2 output
	input wire logic i_cmp1_sync_sel, // Comparator 1 synchronized when high
	input wire logic i_cmp2_sync_sel, // Comparator 2 synchronized when high
	output logic o_secondary_osc_enable, // Crystal oscillator run request
	output logic [15:0] o_count, // Counter value
	output logic o_overflow_flag // Overflow flag
);
	typedef struct packed {
		logic [15:0] count;
		logic [2:0] presc;
		logic [1:0] instr_div;
		logic [7:0] cc;
		logic [7:0] gc;
		logic ovf;
		logic toggle;
		logic armed;
		logic [1:0] ext_sync;
		logic [1:0] gate_sync;
		logic [1:0] lf_sync;
		logic ext_prev;
		logic lf_prev;
		logic gate_prev;
		logic ack;
		logic [31:0] rdata;
	} gtc_state_t;

	gtc_state_t cur_ff;
	gtc_state_t nxt_cur;

	logic [1:0] cs;
	logic ext_raw;
	logic ext_lvl;
	logic ext_rise;
	logic ext_fall;
	logic lf_rise;
	logic tick;
	logic presc_done;
	logic [2:0] presc_limit;
	logic gate_src;
	logic gate_lvl;
	logic gate_active;
	logic gate_rise;
	logic run;
	logic inc;
	logic bus_req;
	logic wr_count;
	logic [7:0] wb_byte;

	// ==========================================
	// Source selection and edge detection
	always_comb
	begin
		cs = cur_ff.cc[gtc_pkg::CC_CS_LSB +: 2];
		ext_raw = cur_ff.cc[gtc_pkg::CC_SECONDARY_OSCILLATOR_EN_BIT] ? i_secondary_oscillator : i_ext_clock_input;
		// unsynchronized when sync disabled; second stage only otherwise
		ext_lvl = cur_ff.cc[gtc_pkg::CC_SYNC_DIS_BIT] ? ext_raw : cur_ff.ext_sync[1];
		ext_rise = ext_lvl && !cur_ff.ext_prev;
		ext_fall = !ext_lvl && cur_ff.ext_prev;
		lf_rise = cur_ff.lf_sync[1] && !cur_ff.lf_prev;
		// source decode; internal sources ignore sync bit
		unique case (cs)
			gtc_pkg::CS_INSTR: tick = (cur_ff.instr_div == gtc_pkg::INSTR_DIV_LAST);
			// full rate gives four counts per instruction
			gtc_pkg::CS_SYSCLK: tick = 1'b1;
			// rising edges; only once armed by a falling edge
			gtc_pkg::CS_EXTERNAL: tick = ext_rise && cur_ff.armed;
			gtc_pkg::CS_LFOSC: tick = lf_rise;
		endcase
		// prescale 1,2,4,8
		// Three-bit count so that divide by eight has room to wrap
		presc_limit = 3'((4'h1 << cur_ff.cc[gtc_pkg::CC_PRESC_LSB +: 2]) - 4'h1);
		presc_done = (cur_ff.presc == presc_limit);
		// gate source; wrap pulse; comparator sync choice
		unique case (cur_ff.gc[gtc_pkg::GC_GSS_LSB +: 2])
			gtc_pkg::GS_PIN: gate_src = cur_ff.gate_sync[1];
			gtc_pkg::GS_TIMER_OVF: gate_src = i_other_8bit_timer_wrap;
			gtc_pkg::GS_CMP1: gate_src = i_cmp1_sync_sel ? cur_ff.gate_sync[1] : i_cmp1_out;
			gtc_pkg::GS_CMP2: gate_src = i_cmp2_sync_sel ? cur_ff.gate_sync[1] : i_cmp2_out;
		endcase
		gate_lvl = cur_ff.gc[gtc_pkg::GC_POL_BIT] ? gate_src : !gate_src;
		gate_rise = gate_lvl && !cur_ff.gate_prev;
		// toggle flip-flop stands in for the gate level
		gate_active = cur_ff.gc[gtc_pkg::GC_TOGGLE_BIT] ? cur_ff.toggle : gate_lvl;
		// enable table; hold while gate inactive
		run = cur_ff.cc[gtc_pkg::CC_ON_BIT] && (!cur_ff.gc[gtc_pkg::GC_EN_BIT] || gate_active);
		bus_req = i_wb_cyc && i_wb_stb && !cur_ff.ack;
		wr_count = bus_req && i_wb_we && i_wb_sel[0] &&
			(i_wb_adr == gtc_pkg::ADDR_COUNT_LOW || i_wb_adr == gtc_pkg::ADDR_COUNT_HIGH);
		inc = run && tick && presc_done && !wr_count;
		wb_byte = i_wb_dat[7:0];
	end

	// ==========================================
	// Next state
	always_comb
	begin
		nxt_cur = cur_ff;
		nxt_cur.ext_sync = {cur_ff.ext_sync[0], ext_raw};
		nxt_cur.lf_sync = {cur_ff.lf_sync[0], i_low_freq_internal_osc};
		nxt_cur.gate_sync = {cur_ff.gate_sync[0],
			(cur_ff.gc[gtc_pkg::GC_GSS_LSB +: 2] == gtc_pkg::GS_CMP1) ? i_cmp1_out :
			(cur_ff.gc[gtc_pkg::GC_GSS_LSB +: 2] == gtc_pkg::GS_CMP2) ? i_cmp2_out : i_gate_input_pin};
		nxt_cur.ext_prev = ext_lvl;
		nxt_cur.lf_prev = cur_ff.lf_sync[1];
		nxt_cur.gate_prev = gate_lvl;
		nxt_cur.instr_div = cur_ff.instr_div + 2'h1;
		if (ext_fall)
			nxt_cur.armed = 1'b1;
		if (run && tick)
			nxt_cur.presc = presc_done ? 3'h0 : cur_ff.presc + 3'h1;
		// count advance; switching sync mode may slip one edge
		if (inc)
			nxt_cur.count = cur_ff.count + 16'h0001;
		// flag on wrap, set wins over a software clear below
		// toggle on each incrementing gate edge
		if (gate_rise)
			nxt_cur.toggle = !cur_ff.toggle;
		// ==========================================
		// Wishbone slave: one-cycle answer, ack drops the next cycle
		nxt_cur.ack = bus_req;
		nxt_cur.rdata = 32'h0000_0000;
		if (bus_req && !i_wb_we)
		begin
			// reads come from registered state, except the gate value bit, which shows live gate_active
			unique case (i_wb_adr)
				gtc_pkg::ADDR_COUNT_LOW: nxt_cur.rdata = {24'h000000, cur_ff.count[7:0]};
				gtc_pkg::ADDR_COUNT_HIGH: nxt_cur.rdata = {24'h000000, cur_ff.count[15:8]};
				gtc_pkg::ADDR_COUNTER_CONTROL: nxt_cur.rdata = {24'h000000, cur_ff.cc};
				gtc_pkg::ADDR_GATE_CONTROL: nxt_cur.rdata = {24'h000000, cur_ff.gc[7:4],
					cur_ff.ovf, gate_active, cur_ff.gc[1:0]};
				default: nxt_cur.rdata = 32'h0000_0000;
			endcase
		end
		if (bus_req && i_wb_we && i_wb_sel[0])
		begin
			unique case (i_wb_adr)
				gtc_pkg::ADDR_COUNT_LOW:
				begin
					// direct load; prescaler clear; re-arm; contention left to software
					nxt_cur.count[7:0] = wb_byte;
					nxt_cur.presc = 3'h0;
					nxt_cur.armed = 1'b0;
				end
				gtc_pkg::ADDR_COUNT_HIGH:
				begin
					nxt_cur.count[15:8] = wb_byte;
					nxt_cur.presc = 3'h0;
					nxt_cur.armed = 1'b0;
				end
				gtc_pkg::ADDR_COUNTER_CONTROL:
				begin
					// oscillator enable bit stored here; settle wait is software's
					nxt_cur.cc = wb_byte & gtc_pkg::CC_WRITE_MASK;
					if (!wb_byte[gtc_pkg::CC_ON_BIT])
						nxt_cur.armed = 1'b0;
				end
				gtc_pkg::ADDR_GATE_CONTROL:
				begin
					// polarity and toggle in one write is software's hazard
					nxt_cur.gc = wb_byte & gtc_pkg::GC_WRITE_MASK;
					if (!wb_byte[gtc_pkg::GC_OVF_FLAG_BIT])
						nxt_cur.ovf = 1'b0;
				end
				default: nxt_cur.cc = cur_ff.cc;
			endcase
		end
		// wrap sets flag, winning over a clear
		if (inc && cur_ff.count == gtc_pkg::COUNT_MAX)
			nxt_cur.ovf = 1'b1;
		// toggle held clear; off clears gate flip-flop
		if (!nxt_cur.gc[gtc_pkg::GC_TOGGLE_BIT] || !nxt_cur.cc[gtc_pkg::CC_ON_BIT])
			nxt_cur.toggle = 1'b0;
		if (!nxt_cur.cc[gtc_pkg::CC_ON_BIT])
			nxt_cur.armed = 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	// ==========================================
	// Outputs
	assign o_wb_ack = cur_ff.ack;
	assign o_wb_dat = cur_ff.rdata;
	assign o_count = cur_ff.count;
	assign o_overflow_flag = cur_ff.ovf;
	// oscillator request, kept through sleep by its own domain
	assign o_secondary_osc_enable = cur_ff.cc[gtc_pkg::CC_SECONDARY_OSCILLATOR_EN_BIT];
endmodule : gtc_timer

// ==== testbench/gtc_far_side.sv ====
// Far-side model: clock pins, gate sources and comparator sync selects
`timescale 1ns/1ps
module gtc_far_side (
	input wire logic i_mclk, // clock
	output logic [2:0] o_clk_pins, // ext pin, crystal, low-freq osc
	output logic [3:0] o_gate_src, // pin, wrap, cmp1, cmp2
	output logic [1:0] o_cmp_sync // cmp1 synced, cmp2 left async
);
	initial
	begin
		o_clk_pins = 3'h0;
		o_gate_src = 4'h0;
		o_cmp_sync = 2'h1;
	end
	// ====================
	// Pulse generators, slow enough for the two-flop synchroniser
	task automatic pulse(input int n, input int k);
		repeat (n)
		begin
			repeat (4) @(posedge i_mclk);
			o_clk_pins[k] <= 1'b1;
			repeat (4) @(posedge i_mclk);
			o_clk_pins[k] <= 1'b0;
		end
	endtask : pulse
	task automatic blip(input int k);
		@(posedge i_mclk);
		o_gate_src[k] <= 1'b1;
		@(posedge i_mclk);
		o_gate_src[k] <= 1'b0;
	endtask : blip
endmodule : gtc_far_side

// ==== testbench/gtc_timer_bench.sv ====
// Self-checking bench for the gated timer
`timescale 1ns/1ps
module gtc_timer_bench;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic ovf;
	logic act;
	logic [2:0] clk_pins;
	logic [3:0] gate_src;
	logic [1:0] cmp_sync;
	logic [15:0] v;
	logic [7:0] rv;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	always #2.5 i_mclk = ~i_mclk;
	gtc_far_side far_u (.i_mclk(i_mclk), .o_clk_pins(clk_pins), .o_gate_src(gate_src), .o_cmp_sync(cmp_sync));
	gtc_timer dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_ext_clock_input(clk_pins[0]), .i_secondary_oscillator(clk_pins[1]),
		.i_low_freq_internal_osc(clk_pins[2]), .i_gate_input_pin(gate_src[0]),
		.i_other_8bit_timer_wrap(gate_src[1]), .i_cmp1_out(gate_src[2]), .i_cmp2_out(gate_src[3]),
		.i_cmp1_sync_sel(cmp_sync[0]), .i_cmp2_sync_sel(cmp_sync[1]), .o_secondary_osc_enable(),
		.o_count(v), .o_overflow_flag(ovf));
	// ====================
	// Bus and compare helpers; ack and read data are taken at the rising edge that sees ack
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do
			@(posedge i_mclk);
		while (ack !== 1'b1);
		rv = rdat[7:0];
		cyc <= 1'b0;
	endtask : bus
	task automatic chk(input string nm, input logic [15:0] got, input int lo, input int hi);
		comparisons++;
		if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1))
		begin
			failures++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk
	// Counter is always stopped before its bytes are written, so no write races an increment
	task automatic run(input string nm, input logic [7:0] cc, input logic [7:0] gc, input int ln, input int lo,
		input int hi);
		bus(1'b1, gtc_pkg::ADDR_COUNT_LOW, 8'h00);
		bus(1'b1, gtc_pkg::ADDR_COUNT_HIGH, 8'h00);
		bus(1'b1, gtc_pkg::ADDR_GATE_CONTROL, gc);
		bus(1'b1, gtc_pkg::ADDR_COUNTER_CONTROL, cc);
		if (ln < 3)
			far_u.pulse(5, ln);
		else if (ln < 7)
			far_u.blip(ln - 3);
		if (ln > 2)
			repeat (62) @(posedge i_mclk);
		bus(1'b1, gtc_pkg::ADDR_COUNTER_CONTROL, 8'h00);
		bus(1'b0, gtc_pkg::ADDR_COUNT_LOW, 8'h00);
		chk({nm, " low"}, {8'h00, rv}, lo % 256, hi % 256);
	endtask : run
	task automatic final_report();
		if (failures == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			final_report();
		end
	end
	initial
	begin
		repeat (2) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (int a = 0; a < 16; a += 2)
		begin
			bus(1'b0, 4'(a), 8'h00);
			chk("reset read", {8'h00, rv & 8'hFB}, 0, 0);
		end
		bus(1'b1, gtc_pkg::ADDR_COUNT_LOW, 8'hA5);
		bus(1'b1, gtc_pkg::ADDR_COUNT_HIGH, 8'h3C);
		bus(1'b0, gtc_pkg::ADDR_COUNT_HIGH, 8'h00);
		chk("count high", {8'h00, rv}, 8'h3C, 8'h3C);
		run("off", 8'h40, 8'h80, 7, 0, 0);
		for (int s = 0; s < 2; s++)
			for (int p = 0; p < 4; p++)
				run("internal", 8'(s * 68 + p * 16 + 1), 8'h00, 7, 64 / ((4 - 3 * s) << p) - 1,
					64 / ((4 - 3 * s) << p) + 1);
		run("ext sync", 8'h81, 8'h00, 0, 4, 4);
		run("ext async", 8'h85, 8'h00, 0, 4, 4);
		run("crystal", 8'h89, 8'h00, 1, 4, 4);
		run("low freq", 8'hC1, 8'h00, 2, 4, 5);
		for (int p = 0; p < 2; p++)
			for (int g = 0; g < 4; g++)
				for (int a = 0; a < 2; a++)
				begin
					act = ((g == 1) ? 0 : a) == p;
					far_u.o_gate_src <= a ? 4'hD : 4'h0;
					run("gate", 8'h41, 8'(128 + p * 64 + g), 7, act ? 56 : 0, act ? 66 : 0);
				end
		far_u.o_gate_src <= 4'h0;
		run("wrap gate", 8'h41, 8'hC1, 4, 1, 2);
		run("toggle idle", 8'h41, 8'hE0, 7, 0, 0);
		run("toggle", 8'h41, 8'hE0, 3, 50, 66);
		bus(1'b1, gtc_pkg::ADDR_GATE_CONTROL, 8'h00);
		bus(1'b1, gtc_pkg::ADDR_COUNT_HIGH, 8'hFC);
		bus(1'b1, gtc_pkg::ADDR_COUNT_LOW, 8'h00);
		bus(1'b1, gtc_pkg::ADDR_COUNTER_CONTROL, 8'h41);
		n = 0;
		while (ovf !== 1'b1)
		begin
			@(negedge i_mclk);
			n++;
		end
		chk("overflow delay", 16'(n), 1020, 1026);
		bus(1'b1, gtc_pkg::ADDR_COUNTER_CONTROL, 8'h00);
		bus(1'b0, gtc_pkg::ADDR_GATE_CONTROL, 8'h00);
		chk("flag set", {8'h00, rv & 8'h08}, 8, 8);
		bus(1'b1, gtc_pkg::ADDR_GATE_CONTROL, 8'h00);
		bus(1'b0, gtc_pkg::ADDR_GATE_CONTROL, 8'h00);
		chk("flag clear", {8'h00, rv & 8'h08}, 0, 0);
		final_report();
	end
endmodule : gtc_timer_bench

// ==== testbench/gtc_timer_checker.sv ====
// Concurrent checks on the timer's bus and count behaviour
`timescale 1ns/1ps
module gtc_timer_checker (
	input wire logic i_mclk, // clock
	input wire logic i_rst, // reset
	input wire logic i_wb_cyc, // cycle
	input wire logic i_wb_stb, // strobe
	input wire logic i_wb_we, // write
	input wire logic [3:0] i_wb_adr, // address
	input wire logic [3:0] i_wb_sel, // selects
	input wire logic [31:0] i_wb_dat, // write data
	input wire logic i_gate_input_pin, // gate pin
	input wire logic [31:0] o_wb_dat, // read data
	input wire logic o_wb_ack, // ack
	input wire logic o_secondary_osc_enable, // osc request
	input wire logic [15:0] o_count, // count
	input wire logic o_overflow_flag // flag
);
	// ====================
	// Shadow of the control bytes
	logic tk;
	logic tkw;
	logic wr;
	logic [7:0] cc_ff;
	logic [7:0] gc_ff;
	assign tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign tkw = tk && i_wb_we;
	assign wr = tkw && i_wb_sel[0];
	always_ff @(posedge i_mclk or posedge i_rst)
		if (i_rst)
			cc_ff <= 8'h00;
		else if (wr && i_wb_adr == gtc_pkg::ADDR_COUNTER_CONTROL)
			cc_ff <= i_wb_dat[7:0] & gtc_pkg::CC_WRITE_MASK;
	always_ff @(posedge i_mclk or posedge i_rst)
		if (i_rst)
			gc_ff <= 8'h00;
		else if (wr && i_wb_adr == gtc_pkg::ADDR_GATE_CONTROL)
			gc_ff <= i_wb_dat[7:0];
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	chk_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	chk_ack_next: assert property (tk |=> o_wb_ack)
		else $error("ack missing");
	chk_read_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
		else $error("upper read bits set");
	chk_low_load: assert property (wr && i_wb_adr == gtc_pkg::ADDR_COUNT_LOW |=> o_count[7:0] == i_wb_dat[7:0])
		else $error("low byte write lost");
	chk_off_hold: assert property (!cc_ff[0] && !tkw |=> $stable(o_count))
		else $error("count moved while off");
	chk_sys_step: assert property ($stable({cc_ff, gc_ff}) && cc_ff[7:4] == 4'h4 && cc_ff[0] && !gc_ff[7] && !tkw
		|=> o_count == $past(o_count) + 16'h0001)
		else $error("system clock step wrong");
	chk_gate_hold: assert property ((cc_ff[0] && gc_ff[7] && !gc_ff[5] && gc_ff[1:0] == 2'h0
		&& gc_ff[6] != i_gate_input_pin && !tkw)[*5] |=> $stable(o_count))
		else $error("count moved with gate inactive");
	chk_flag_wrap: assert property (o_count == 16'hFFFF && !tkw ##1 o_count == 16'h0000 |-> ##[0:1] o_overflow_flag)
		else $error("wrap without flag");
	chk_flag_keep: assert property (o_overflow_flag && !(tkw && i_wb_adr == gtc_pkg::ADDR_GATE_CONTROL)
		|=> o_overflow_flag)
		else $error("flag dropped");
	chk_osc_req: assert property (o_secondary_osc_enable == cc_ff[3])
		else $error("oscillator request wrong");
endmodule : gtc_timer_checker
bind gtc_timer gtc_timer_checker chk_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
	.i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
	.i_gate_input_pin(i_gate_input_pin), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_secondary_osc_enable(o_secondary_osc_enable), .o_count(o_count), .o_overflow_flag(o_overflow_flag));
